// ### rtl/frps_consts.vh
// constants for the read-parameter, reset and parameter-area command block
`ifndef FRPS_CONSTS_VH
`define FRPS_CONSTS_VH

// command opcodes
`define FRPS_OP_RDPARAM 8'hc0
`define FRPS_OP_RST_EN 8'h66
`define FRPS_OP_RST 8'h99
`define FRPS_OP_PAREAD 8'h5a
`define FRPS_OP_QUAD_ON 8'h38
`define FRPS_OP_QUAD_OFF 8'hff

// read-parameter fields and reset values
`define FRPS_DUMMY_MSB 5
`define FRPS_DUMMY_LSB 4
`define FRPS_WRAP_MSB 1
`define FRPS_WRAP_LSB 0
`define FRPS_DUMMY_RST 2'h0
`define FRPS_WRAP_RST 2'h0
`define FRPS_DUMMY_LOW 4'h4
`define FRPS_DUMMY_HIGH 4'h6
`define FRPS_WRAP_8 7'h08
`define FRPS_WRAP_16 7'h10
`define FRPS_WRAP_32 7'h20
`define FRPS_WRAP_64 7'h40

// parameter-area read framing
`define FRPS_PA_ADDR_BITS 24
`define FRPS_PA_DUMMY_CLKS 8
`define FRPS_PA_SIZE 2048
`define FRPS_PA_BLANK 8'hff

// reset recovery time
`define FRPS_TRST_NS 30000
`define FRPS_CLK_NS 8

`endif

// ### rtl/frps_flash_cmd.v
// command logic: read parameters, software reset, parameter-area read
// How it works
// (R1) four-wire mode: C0h sets dummy and wrap
// (R2) standard serial mode ignores C0h; fixed dummies
// (R3) reset values: wrap 8 bytes, dummy 4
// (R4) dummy code 00/01 gives 4, 10 gives 6
// (R5) wrap code selects 8, 16, 32, 64 bytes
// (R6) accepted reset clears all volatile state
// (R7) 66h and 99h work in both modes
// (R8) reset only when 99h directly follows 66h
// (R9) ignore commands about 30 us after reset
// (R10) host checks busy and suspend before reset; the bench resets with the suspend flag set
// (R11) 2048-byte read-only area, unset bytes FFh
// (R12) 5Ah, 24-bit address, 8 dummies, then data
// (R13) data bits change on falling serial clock
// (R14) raising chip select ends the read
// (R15) signature and top header bytes fixed
// (R16) first parameter header bytes fixed
// (R17) second parameter header bytes fixed
// (R18) powers up serial; 38h needs quad enable
// (R19) dummy code 11 keeps 4 clocks
`timescale 1ns/100ps
`include "frps_consts.vh"

module frps_flash_cmd #(
    parameter TRST_CYCLES = (`FRPS_TRST_NS + `FRPS_CLK_NS - 1) / `FRPS_CLK_NS,
    parameter [7:0] MAKER_CODE = 8'h5c // arbitrary identity value
) (
    input wire clk_sys,
    input wire rstn,
    input wire cs_n,
    input wire sck,
    input wire [3:0] io_in,
    output reg [3:0] io_out,
    output reg [3:0] io_oe_n,
    input wire quad_enable_bit,
    input wire busy_in,
    output reg four_wire_command_mode,
    output reg [3:0] dummy_clocks,
    output reg [6:0] wrap_length,
    output reg [1:0] dummy_clock_select,
    output reg [1:0] wrap_length_select,
    output reg write_enable_latch_flag,
    output reg suspend_status_flag,
    output reg cont_read_mode_flag,
    output reg reset_enabled,
    output wire reset_busy,
    output reg reset_pulse,
    input wire set_write_enable,
    input wire set_suspend,
    input wire set_cont_read
);

// ---------------------------------------------------------------------
// reset release and pin synchronisers
// ---------------------------------------------------------------------
reg [1:0] rst_sync_ff;
wire rst_n_int = rst_sync_ff[1];

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        rst_sync_ff <= 2'h0;
    end else begin
        rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
end

reg [5:0] pin_a_ff;
reg [5:0] pin_b_ff;
reg sck_prev_ff;
reg cs_prev_ff;

always @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
        pin_a_ff <= 6'h3f;
        pin_b_ff <= 6'h3f;
        sck_prev_ff <= 1'b0;
        cs_prev_ff <= 1'b1;
    end else begin
        pin_a_ff <= {cs_n, sck, io_in};
        pin_b_ff <= pin_a_ff;
        sck_prev_ff <= pin_b_ff[4];
        cs_prev_ff <= pin_b_ff[5];
    end
end

wire cs_n_s = pin_b_ff[5];
wire sck_s = pin_b_ff[4];
wire [3:0] io_s = pin_b_ff[3:0];
wire sck_rise = sck_s & ~sck_prev_ff & ~cs_n_s;
wire sck_fall = ~sck_s & sck_prev_ff & ~cs_n_s;
// only the opening of a frame may start a command, so trailing bits
// after a finished opcode are never decoded as a second command
wire frame_start = cs_prev_ff & ~cs_n_s;

// ---------------------------------------------------------------------
// decode functions
// ---------------------------------------------------------------------
function [3:0] dummy_decode;
    input [1:0] code;
    begin
        // code 11 is reserved and falls back to the short setting
        if (code == 2'h2) begin
            dummy_decode = `FRPS_DUMMY_HIGH; // [R4]
        end else begin
            dummy_decode = `FRPS_DUMMY_LOW; // [R4] [R19]
        end
    end
endfunction

function [6:0] wrap_decode;
    input [1:0] code;
    begin
        case (code) // [R5]
            2'h0: wrap_decode = `FRPS_WRAP_8;
            2'h1: wrap_decode = `FRPS_WRAP_16;
            2'h2: wrap_decode = `FRPS_WRAP_32;
            default: wrap_decode = `FRPS_WRAP_64;
        endcase
    end
endfunction

// unlisted bytes past 17h read as erased; byte 17h reads 01h; the table body is not held here
function [7:0] area_byte;
    input [23:0] addr;
    begin
        area_byte = `FRPS_PA_BLANK; // [R11]
        if (addr < 24'h000018) begin
            case (addr[4:0])
                5'h00: area_byte = 8'h53; // [R15]
                5'h01: area_byte = 8'h46;
                5'h02: area_byte = 8'h44;
                5'h03: area_byte = 8'h50;
                5'h04: area_byte = 8'h06;
                5'h05: area_byte = 8'h01;
                5'h06: area_byte = 8'h01;
                5'h07: area_byte = 8'hff;
                5'h08: area_byte = 8'h00; // [R16]
                5'h09: area_byte = 8'h06;
                5'h0a: area_byte = 8'h01;
                5'h0b: area_byte = 8'h10;
                5'h0c: area_byte = 8'h30;
                5'h0d: area_byte = 8'h00;
                5'h0e: area_byte = 8'h00;
                5'h0f: area_byte = 8'hff;
                5'h10: area_byte = MAKER_CODE; // [R17]
                5'h11: area_byte = 8'h00;
                5'h12: area_byte = 8'h01;
                5'h13: area_byte = 8'h02;
                5'h14: area_byte = 8'h80;
                5'h15: area_byte = 8'h00;
                5'h16: area_byte = 8'h00;
                default: area_byte = 8'h01;
            endcase
        end
    end
endfunction

// ---------------------------------------------------------------------
// frame state machine
// ---------------------------------------------------------------------
localparam [5:0] ST_IDLE = 6'h01;
localparam [5:0] ST_OPC = 6'h02;
localparam [5:0] ST_ADDR = 6'h04;
localparam [5:0] ST_DUMMY = 6'h08;
localparam [5:0] ST_DATA = 6'h10;
localparam [5:0] ST_ARG = 6'h20;

reg [5:0] state_ff;
reg [5:0] bit_cnt_ff;
reg [7:0] opc_ff;
reg [23:0] addr_ff;
reg [7:0] shift_ff;
reg [2:0] out_bit_ff;
reg opc_done_ff;
reg [15:0] rst_cnt_ff;

wire [7:0] opc_next = four_wire_command_mode ? {opc_ff[3:0], io_s} :
                      {opc_ff[6:0], io_s[0]};
wire [5:0] opc_bits = four_wire_command_mode ? 6'd4 : 6'd1;
wire [10:0] area_idx = addr_ff[10:0];
assign reset_busy = (rst_cnt_ff != 16'h0000);

always @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
        state_ff <= ST_IDLE;
        bit_cnt_ff <= 6'h00;
        opc_ff <= 8'h00;
        addr_ff <= 24'h000000;
        shift_ff <= 8'hff;
        out_bit_ff <= 3'h0;
        opc_done_ff <= 1'b0;
        io_out <= 4'h0;
        io_oe_n <= 4'hf;
        four_wire_command_mode <= 1'b0; // [R18]
        dummy_clock_select <= `FRPS_DUMMY_RST; // [R3]
        wrap_length_select <= `FRPS_WRAP_RST;
        write_enable_latch_flag <= 1'b0;
        suspend_status_flag <= 1'b0;
        cont_read_mode_flag <= 1'b0;
        reset_enabled <= 1'b0;
        reset_pulse <= 1'b0;
        rst_cnt_ff <= 16'h0000;
    end else begin
        reset_pulse <= 1'b0;
        opc_done_ff <= 1'b0;
        if (set_write_enable) begin
            write_enable_latch_flag <= 1'b1;
        end
        if (set_suspend) begin
            suspend_status_flag <= 1'b1;
        end
        if (set_cont_read) begin
            cont_read_mode_flag <= 1'b1;
        end
        if (reset_busy) begin
            rst_cnt_ff <= rst_cnt_ff - 16'h0001; // [R9]
        end
        if (cs_n_s) begin
            state_ff <= ST_IDLE; // [R14]
            io_oe_n <= 4'hf;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    // a frame opened during reset recovery is dropped whole
                    if (frame_start && !reset_busy) begin // [R9]
                        state_ff <= ST_OPC;
                        bit_cnt_ff <= 6'h00;
                    end
                end
                ST_OPC: begin
                    if (sck_rise) begin
                        opc_ff <= opc_next;
                        bit_cnt_ff <= bit_cnt_ff + opc_bits;
                        if (bit_cnt_ff + opc_bits == 6'd8) begin
                            opc_done_ff <= 1'b1;
                            bit_cnt_ff <= 6'h00;
                            state_ff <= ST_IDLE;
                            reset_enabled <= 1'b0; // [R8]
                            if (opc_next == `FRPS_OP_RST_EN) begin
                                reset_enabled <= 1'b1; // [R7]
                            end else if (opc_next == `FRPS_OP_RST &&
                                         reset_enabled) begin
                                reset_pulse <= 1'b1; // [R7] [R8]
                                rst_cnt_ff <= TRST_CYCLES[15:0];
                                four_wire_command_mode <= 1'b0; // [R6]
                                dummy_clock_select <= `FRPS_DUMMY_RST;
                                wrap_length_select <= `FRPS_WRAP_RST;
                                write_enable_latch_flag <= 1'b0;
                                suspend_status_flag <= 1'b0;
                                cont_read_mode_flag <= 1'b0;
                            end else if (opc_next == `FRPS_OP_RDPARAM &&
                                         four_wire_command_mode) begin
                                state_ff <= ST_ARG; // [R1] [R2]
                            end else if (opc_next == `FRPS_OP_PAREAD) begin
                                state_ff <= ST_ADDR; // [R12]
                            end else if (opc_next == `FRPS_OP_QUAD_ON &&
                                         quad_enable_bit) begin
                                four_wire_command_mode <= 1'b1; // [R18]
                            end else if (opc_next == `FRPS_OP_QUAD_OFF &&
                                         four_wire_command_mode) begin
                                four_wire_command_mode <= 1'b0;
                            end
                        end
                    end
                end
                ST_ARG: begin
                    if (sck_rise) begin
                        shift_ff <= {shift_ff[3:0], io_s};
                        bit_cnt_ff <= bit_cnt_ff + 6'd4;
                        if (bit_cnt_ff == 6'd4) begin
                            dummy_clock_select <= shift_ff[1:0]; // [R1]
                            wrap_length_select <= io_s[1:0];
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR: begin
                    if (sck_rise) begin
                        addr_ff <= four_wire_command_mode ?
                            {addr_ff[19:0], io_s} : {addr_ff[22:0], io_s[0]};
                        bit_cnt_ff <= bit_cnt_ff + opc_bits;
                        if (bit_cnt_ff + opc_bits == `FRPS_PA_ADDR_BITS) begin
                            bit_cnt_ff <= 6'h00;
                            state_ff <= ST_DUMMY; // [R12]
                        end
                    end
                end
                ST_DUMMY: begin
                    if (sck_rise) begin
                        bit_cnt_ff <= bit_cnt_ff + 6'd1;
                        if (bit_cnt_ff == `FRPS_PA_DUMMY_CLKS - 1) begin
                            shift_ff <= area_byte({13'h0000, area_idx});
                            out_bit_ff <= 3'h7;
                            state_ff <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    // output changes on the falling edge only
                    if (sck_fall) begin // [R13]
                        io_oe_n[1] <= 1'b0;
                        io_out[1] <= shift_ff[out_bit_ff];
                        out_bit_ff <= out_bit_ff - 3'h1;
                        if (out_bit_ff == 3'h0) begin
                            addr_ff <= {13'h0000, area_idx + 11'h001};
                            shift_ff <= area_byte({13'h0000,
                                area_idx + 11'h001}); // [R11]
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
end

// ---------------------------------------------------------------------
// decoded read settings, held as registers
// ---------------------------------------------------------------------
always @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
        dummy_clocks <= `FRPS_DUMMY_LOW; // [R3]
        wrap_length <= `FRPS_WRAP_8;
    end else begin
        dummy_clocks <= dummy_decode(dummy_clock_select); // [R4]
        wrap_length <= wrap_decode(wrap_length_select); // [R5]
    end
end

endmodule

// ### testbench/frps_host_model.sv
// host controller model that drives chip select, serial clock and io
`timescale 1ns/100ps
module frps_host_model (
    input wire clk_sys,
    output reg cs_n,
    output reg sck,
    output reg [3:0] io_in,
    input wire [3:0] io_out,
    input wire [3:0] io_oe_n
);
    reg [7:0] rx [0:31];
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        io_in = 4'h0;
    end
    // half period of 8 system clocks keeps the link far below its limit
    task tick(input logic lvl);
        begin
            sck <= lvl;
            repeat (8) @(negedge clk_sys);
        end
    endtask
    // n units msb first, a nibble each in quad mode, then nrd bits back
    task xfer(input logic quad, input logic [63:0] bits, input integer n,
        input integer nrd);
        integer i;
        begin
            cs_n <= 1'b0;
            for (i = n - 1; i >= 0; i = i - 1) begin
                io_in <= quad ? bits[4*i +: 4] : {3'h0, bits[i]};
                tick(1'b0);
                tick(1'b1);
            end
            // a released line must not keep showing the last bit
            io_in <= ~io_in;
            for (i = 0; i < nrd; i = i + 1) begin
                tick(1'b0);
                // an undriven data line floats high on its pull-up
                rx[i/8] = {rx[i/8][6:0], io_oe_n[1] | io_out[1]};
                tick(1'b1);
            end
            tick(1'b0);
            cs_n <= 1'b1;
            repeat (8) @(negedge clk_sys);
        end
    endtask
endmodule

// ### testbench/frps_flash_cmd_assertions.sv
// concurrent checks on the command block ports
`timescale 1ns/100ps
module frps_flash_cmd_assertions #(
    parameter TRST_CYCLES = 3750
) (
    input wire clk_sys,
    input wire rstn,
    input wire cs_n,
    input wire sck,
    input wire quad_enable_bit,
    input wire [3:0] io_oe_n,
    input wire [3:0] io_out,
    input wire four_wire_command_mode,
    input wire [3:0] dummy_clocks,
    input wire [6:0] wrap_length,
    input wire [1:0] dummy_clock_select,
    input wire [1:0] wrap_length_select,
    input wire write_enable_latch_flag,
    input wire reset_enabled,
    input wire reset_busy,
    input wire reset_pulse
);
    reg [15:0] busy_cnt_ff;
    wire [15:0] nxt_busy_cnt;
    assign nxt_busy_cnt = reset_busy ? busy_cnt_ff + 16'h1 : 16'h0;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            busy_cnt_ff <= 16'h0;
        end else begin
            busy_cnt_ff <= nxt_busy_cnt;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    property p_serial_fixed;
        // a reset accepted in serial mode still clears the fields
        !four_wire_command_mode && !reset_busy && !reset_pulse |=>
            reset_pulse ||
            ($stable(dummy_clock_select) && $stable(wrap_length_select));
    endproperty
    a_serial_fixed: assert property (p_serial_fixed)
        else $error("read parameters changed in serial mode");
    property p_dummy_map;
        $stable(dummy_clock_select) |->
            dummy_clocks == ((dummy_clock_select == 2'h2) ? 4'h6 : 4'h4);
    endproperty
    a_dummy_map: assert property (p_dummy_map)
        else $error("dummy count does not match its code");
    property p_wrap_map;
        $stable(wrap_length_select) |->
            wrap_length == (7'h08 << wrap_length_select);
    endproperty
    a_wrap_map: assert property (p_wrap_map)
        else $error("wrap length does not match its code");
    property p_reset_clear;
        reset_pulse |-> ##[1:3] (dummy_clocks == 4'h4 &&
            wrap_length == 7'h08 && !four_wire_command_mode &&
            !write_enable_latch_flag);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("state not cleared after reset");
    property p_pulse_gate;
        reset_pulse |-> $past(reset_enabled) ##1 !reset_pulse;
    endproperty
    a_pulse_gate: assert property (p_pulse_gate)
        else $error("reset without armed enable");
    property p_busy_quiet;
        reset_busy && $past(reset_busy) |->
            !reset_pulse && !$rose(four_wire_command_mode);
    endproperty
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("command taken during reset recovery");
    property p_busy_len;
        $fell(reset_busy) |-> busy_cnt_ff + 16'h2 >= TRST_CYCLES &&
            busy_cnt_ff <= TRST_CYCLES + 2;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("reset recovery length wrong");
    property p_release_drive;
        cs_n [*6] |-> io_oe_n == 4'hf;
    endproperty
    a_release_drive: assert property (p_release_drive)
        else $error("io driven while deselected");
    property p_quad_gate;
        $rose(four_wire_command_mode) |-> $past(quad_enable_bit);
    endproperty
    a_quad_gate: assert property (p_quad_gate)
        else $error("four-wire mode entered without quad enable");
    // the output bit moves a few system clocks after the serial clock falls
    property p_out_on_fall;
        $changed(io_out) |-> !sck;
    endproperty
    a_out_on_fall: assert property (p_out_on_fall)
        else $error("data output changed while serial clock high");
endmodule

bind frps_flash_cmd frps_flash_cmd_assertions #(
    .TRST_CYCLES(TRST_CYCLES)
) u_chk (.clk_sys, .rstn, .cs_n, .sck, .quad_enable_bit, .io_oe_n,
    .io_out,
    .four_wire_command_mode, .dummy_clocks, .wrap_length,
    .dummy_clock_select, .wrap_length_select, .write_enable_latch_flag,
    .reset_enabled, .reset_busy, .reset_pulse);

// ### testbench/frps_flash_cmd_bench.sv
// self-checking bench for the command block
`timescale 1ns/100ps
module frps_flash_cmd_bench;
    localparam [7:0] MAKER = 8'h3a; // arbitrary identity value
    reg clk_sys, rstn, quad_enable_bit, busy_in;
    reg set_write_enable, set_suspend, set_cont_read;
    wire cs_n, sck, four_wire_command_mode, write_enable_latch_flag;
    wire suspend_status_flag, cont_read_mode_flag, reset_enabled;
    wire reset_busy, reset_pulse;
    wire [3:0] io_in, io_out, io_oe_n, dummy_clocks;
    wire [6:0] wrap_length;
    wire [1:0] dummy_clock_select, wrap_length_select;
    integer fail_count = 0;
    integer samples_checked = 0;
    integer i;
    // argument, then dummy count and wrap length it should give
    logic [18:0] rows [0:3] = '{{8'h00, 4'h4, 7'h08},
        {8'h11, 4'h4, 7'h10}, {8'h22, 4'h6, 7'h20}, {8'h33, 4'h4, 7'h40}};
    logic [191:0] sig = {64'h53464450060101ff, 64'h00060110300000ff,
        MAKER, 56'h00010280000001};
    frps_flash_cmd #(.TRST_CYCLES(400), .MAKER_CODE(MAKER)) DUT (
        .clk_sys, .rstn, .cs_n, .sck, .io_in, .io_out, .io_oe_n,
        .quad_enable_bit, .busy_in, .four_wire_command_mode, .dummy_clocks,
        .wrap_length, .dummy_clock_select, .wrap_length_select,
        .write_enable_latch_flag, .suspend_status_flag, .cont_read_mode_flag,
        .reset_enabled, .reset_busy, .reset_pulse, .set_write_enable,
        .set_suspend, .set_cont_read);
    frps_host_model host (.clk_sys, .cs_n, .sck, .io_in, .io_out, .io_oe_n);
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                $display("unexpected at %0t: got %h expected %h", $time, got,
                    exp);
                fail_count = fail_count + 1;
            end
        end
    endtask
    task wait_idle;
        integer n;
        begin
            n = 0;
            while (reset_busy !== 1'b0 && n < 1000) begin
                @(negedge clk_sys);
                n = n + 1;
            end
            chk(n < 1000, 1'b1);
        end
    endtask
    task finish_test;
        begin
            if (fail_count == 0 && samples_checked > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask
    initial begin
        #600000;
        fail_count = fail_count + 1;
        finish_test;
    end
    initial begin
        {rstn, quad_enable_bit, busy_in} = 3'h0;
        {set_write_enable, set_suspend, set_cont_read} = 3'h0;
        repeat (8) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (10) @(negedge clk_sys);
        chk({four_wire_command_mode, dummy_clocks, wrap_length, io_oe_n},
            {1'b0, 4'h4, 7'h08, 4'hf});
        host.xfer(1'b0, 64'hc022, 16, 0);
        chk(dummy_clocks, 4'h4);
        host.xfer(1'b0, 64'h38, 8, 0);
        chk(four_wire_command_mode, 1'b0);
        quad_enable_bit = 1'b1;
        host.xfer(1'b0, 64'h38, 8, 0);
        chk(four_wire_command_mode, 1'b1);
        for (i = 0; i < 4; i = i + 1) begin
            host.xfer(1'b1, {8'hc0, rows[i][18:11]}, 4, 0);
            chk({dummy_clock_select, wrap_length_select, rows[i][10:0]},
                {rows[i][16:15], rows[i][12:11], dummy_clocks,
                wrap_length});
        end
        {set_write_enable, set_suspend, set_cont_read} = 3'h7;
        @(negedge clk_sys);
        {set_write_enable, set_suspend, set_cont_read} = 3'h0;
        host.xfer(1'b1, 64'h66, 2, 0);
        host.xfer(1'b1, 64'hc022, 4, 0);
        host.xfer(1'b1, 64'h99, 2, 0);
        chk({four_wire_command_mode, dummy_clocks, write_enable_latch_flag},
            {1'b1, 4'h6, 1'b1});
        // busy_in stays low, so the host may start the sequence
        host.xfer(1'b1, 64'h66, 2, 0);
        host.xfer(1'b1, 64'h99, 2, 0);
        host.xfer(1'b0, 64'h38, 8, 0);
        chk({four_wire_command_mode, write_enable_latch_flag,
            suspend_status_flag, cont_read_mode_flag, dummy_clocks,
            wrap_length, reset_busy}, {4'h0, 4'h4, 7'h08, 1'b1});
        wait_idle;
        host.xfer(1'b0, 64'h66, 8, 0);
        host.xfer(1'b0, 64'h99, 8, 0);
        chk(reset_busy, 1'b1);
        wait_idle;
        // a second opcode in the same frame must not complete the reset
        host.xfer(1'b0, 64'h6699, 16, 0);
        chk({reset_busy, reset_enabled}, 2'h1);
        host.xfer(1'b0, {8'h5a, 32'h0}, 40, 192);
        for (i = 0; i < 24; i = i + 1) begin
            chk(host.rx[i], sig[191-8*i -: 8]);
        end
        host.xfer(1'b0, {8'h5a, 24'h7fe, 8'h0}, 40, 24);
        chk({host.rx[0], host.rx[1], host.rx[2]}, 24'hffff53);
        host.xfer(1'b0, {8'h5a, 24'h4, 8'h0}, 40, 4);
        chk(io_oe_n, 4'hf);
        finish_test;
    end
endmodule
